// >>> dv/lseh_motion_model.sv
// partner: motor, load-side encoder, dog and stroke switches
// assumes the bench sets geometry and speed while the block is idle
`timescale 1ns/10ps
module lseh_motion_model
	import lseh_pkg::*;
(
	input wire logic clk,
	input wire logic move_req,
	input wire logic move_dir,
	input wire logic [3:0] div,
	input wire logic preset,
	input lseh_pos_t preset_val,
	input lseh_pos_t ref_at,
	input wire logic ref_en,
	output lseh_pos_t load_pos,
	output logic ref_mark_pin,
	output logic dog_pin,
	output logic stroke_fwd_pin,
	output logic stroke_rev_pin
);
	// ----
	// fixed machine geometry
	// ----
	localparam int DOG_LO = 96; // dog well past any mark
	localparam int DOG_HI = 130;
	localparam int FWD_END = 400;
	localparam int REV_END = -20; // opposite end reachable by jog
	logic [3:0] tick;

	initial begin
		load_pos = '0;
		tick = '0;
	end

	// one count every div cycles while motion is asked for
	always @(posedge clk) begin
		if (preset) begin
			load_pos <= preset_val;
			tick <= '0;
		end else if (move_req) begin
			if (tick + 4'h1 >= div) begin
				tick <= '0;
				load_pos <= move_dir ? load_pos + 32'sd1 : load_pos - 32'sd1;
			end else begin
				tick <= tick + 4'h1;
			end
		end
	end

	// a single mark, a few cycles wide
	assign ref_mark_pin = ref_en && (load_pos == ref_at);
	assign dog_pin = (load_pos >= DOG_LO) && (load_pos < DOG_HI);
	assign stroke_fwd_pin = load_pos >= FWD_END;
	assign stroke_rev_pin = load_pos <= REV_END;
endmodule

// >>> dv/lseh_top_tb_top.sv
// bench for the homing block with the motion partner
// assumes the package and defines header are compiled first
`timescale 1ns/10ps
`include "lseh_defines.svh"
module lseh_top_tb_top
	import lseh_pkg::*;
;
	logic clk;
	logic arst_n;
	lseh_cmd_s cmd;
	lseh_cfg_s cfg;
	lseh_pos_t load_pos;
	lseh_pos_t home_pos;
	lseh_pos_t preset_val;
	lseh_pos_t ref_at;
	logic ref_mark_pin, dog_pin, stroke_fwd_pin, stroke_rev_pin;
	logic busy, done, err, home_valid, move_req, move_dir, index_out;
	logic [2:0] err_code;
	logic [3:0] div;
	logic preset, ref_en, dir0;
	int err_count = 0;
	int total_checks = 0;
	int pulses = 0;

	lseh_top lseh_top_i (.clk(clk), .arst_n(arst_n), .cmd(cmd), .cfg(cfg),
		.load_pos(load_pos), .ref_mark_pin(ref_mark_pin), .dog_pin(dog_pin),
		.stroke_fwd_pin(stroke_fwd_pin), .stroke_rev_pin(stroke_rev_pin), .busy(busy),
		.done(done), .err(err), .err_code(err_code), .home_valid(home_valid),
		.home_pos(home_pos), .move_req(move_req), .move_dir(move_dir),
		.encoder_index_pulse_output(index_out));

	lseh_motion_model lseh_motion_model_i (.clk(clk), .move_req(move_req),
		.move_dir(move_dir), .div(div), .preset(preset), .preset_val(preset_val),
		.ref_at(ref_at), .ref_en(ref_en), .load_pos(load_pos), .ref_mark_pin(ref_mark_pin),
		.dog_pin(dog_pin), .stroke_fwd_pin(stroke_fwd_pin), .stroke_rev_pin(stroke_rev_pin));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(negedge clk) begin
		if (index_out === 1'b1) begin
			pulses++;
		end
	end

	// ----
	// shared tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic place(input int p, input int r, input logic en);
		preset = 1'b1;
		preset_val = p;
		ref_at = r;
		ref_en = en;
		@(negedge clk);
		preset = 1'b0;
		pulses = 0;
	endtask

	task automatic go(input logic [7:0] m);
		int n;
		n = 0;
		cmd.method = m;
		cmd.start = 1'b1;
		@(negedge clk);
		cmd.start = 1'b0;
		@(negedge clk);
		dir0 = move_dir;
		while (!(done === 1'b1 || err === 1'b1) && n < 4000) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		if (n >= 4000) begin
			err_count++;
			$display("unexpected at %0t: homing never ended", $time);
			stop_test();
		end
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_dataset;
		place(55, 0, 1'b0);
		go(`LSEH_METH_DATASET);
		check(err_code, `LSEH_ERR_NOREF);
		check(err, 1'b1);
		check(home_valid, 1'b0);
		cfg.cond_select = 1'b1;
		go(`LSEH_METH_DATASET);
		check(done, 1'b1);
		check(home_pos, 32'd55);
		cfg.cond_select = 1'b0;
		$display("data set test finished");
	endtask

	task automatic t_index;
		cfg.enc_type = `LSEH_ENC_INC_LIN;
		place(0, 40, 1'b1);
		go(`LSEH_METH_IDX_POS);
		check(dir0, 1'b1);
		check(home_pos, 32'd45);
		check({busy, move_req, done}, 32'd1);
		check(pulses, 32'd1);
		place(0, -10, 1'b1);
		go(`LSEH_METH_IDX_NEG);
		check(dir0, 1'b0);
		check(home_pos, -32'sd5);
		$display("index method test finished");
	endtask

	task automatic t_variant_b;
		cfg.variant_b = 1'b1;
		place(0, 40, 1'b1);
		go(`LSEH_METH_IDX_POS);
		check(home_pos, 32'd45);
		check(pulses, 32'd0);
		$display("variant test finished");
	endtask

	task automatic t_dog_grid;
		cfg.enc_type = `LSEH_ENC_ABS_LIN;
		div = 4'h2;
		cmd.shift = 32'sd3;
		place(0, 0, 1'b0);
		go(`LSEH_METH_DOG);
		check(dir0, 1'b1);
		check(home_pos, 32'd195);
		place(0, 0, 1'b0);
		go(`LSEH_METH_REV_NEG);
		check(dir0, 1'b0);
		check(home_pos, 32'd195);
		$display("dog grid test finished");
	endtask

	task automatic t_refusals;
		logic [7:0] ms [4];
		ms = '{`LSEH_METH_REV_POS, `LSEH_METH_REV_NEG, `LSEH_METH_IDX_POS, `LSEH_METH_IDX_NEG};
		cfg.enc_type = `LSEH_ENC_INC_LIN;
		for (int i = 0; i < 4; i++) begin
			cfg.soft_limit_en = i < 2;
			cfg.no_ref_mark = i >= 2;
			go(ms[i]);
			check(err_code, i < 2 ? `LSEH_ERR_SOFTLIM : `LSEH_ERR_NOIDX);
		end
		cfg.soft_limit_en = 1'b0;
		cfg.no_ref_mark = 1'b0;
		$display("refusal test finished");
	endtask

	task automatic t_no_mark_ahead;
		place(0, 0, 1'b0);
		go(`LSEH_METH_DOG);
		check(err_code, `LSEH_ERR_NOREF);
		place(0, 0, 1'b0);
		go(`LSEH_METH_IDX_NEG);
		check(err_code, `LSEH_ERR_NOREF);
		$display("missing mark test finished");
	endtask

	task automatic t_rotary;
		cfg.enc_type = `LSEH_ENC_SER_ROT;
		cmd.shift = 32'sd5;
		div = 4'h8;
		place(0, 40, 1'b1);
		go(`LSEH_METH_IDX_POS);
		check(done, 1'b1);
		check(home_pos, 32'd45);
		$display("rotary test finished");
	endtask

	initial begin
		arst_n = 1'b0;
		cmd = '0;
		cmd.shift = 32'sd5;
		cfg = '0;
		cfg.rev_counts = 32'sd64;
		div = 4'h8;
		preset = 1'b0;
		preset_val = '0;
		ref_at = '0;
		ref_en = 1'b0;
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		check(move_dir, `LSEH_RST_DIR);
		t_dataset();
		t_index();
		t_variant_b();
		t_dog_grid();
		t_refusals();
		t_no_mark_ahead();
		t_rotary();
		stop_test();
	end
endmodule

// >>> pkg/lseh_defines.svh
// constants for the load-side encoder homing block
// assumes inclusion by bare name from the package and the top module
`ifndef LSEH_DEFINES_SVH
`define LSEH_DEFINES_SVH

// --------------------------------------------------------------
// widths
// --------------------------------------------------------------
`define LSEH_POS_W 32
`define LSEH_METH_W 8

// --------------------------------------------------------------
// homing method codes, two's complement
// --------------------------------------------------------------
`define LSEH_METH_DOG 8'hff
`define LSEH_METH_IDX_NEG 8'h21
`define LSEH_METH_IDX_POS 8'h22
`define LSEH_METH_REV_POS 8'hf5
`define LSEH_METH_REV_NEG 8'hd5
`define LSEH_METH_DATASET 8'h25

// --------------------------------------------------------------
// load-side encoder types
// --------------------------------------------------------------
`define LSEH_ENC_ABS_LIN 2'h0
`define LSEH_ENC_INC_LIN 2'h1
`define LSEH_ENC_SER_ROT 2'h2

// --------------------------------------------------------------
// error codes and reset values
// --------------------------------------------------------------
`define LSEH_ERR_NONE 3'h0
`define LSEH_ERR_NOREF 3'h1
`define LSEH_ERR_SOFTLIM 3'h2
`define LSEH_ERR_NOIDX 3'h3
`define LSEH_ERR_BADMETH 3'h4
`define LSEH_RST_DIR 1'h1

`endif

// >>> pkg/lseh_pkg.sv
// types shared by the homing block
// assumes the defines header is on the include path
package lseh_pkg;
`include "lseh_defines.svh"

	typedef enum logic [2:0] {
		LSEH_IDLE = 3'b000,
		LSEH_SEEK = 3'b001,
		LSEH_DOG = 3'b010,
		LSEH_GRID = 3'b011
	} lseh_state_e;

	typedef logic signed [`LSEH_POS_W-1:0] lseh_pos_t;

	typedef struct packed {
		logic start;
		logic [`LSEH_METH_W-1:0] method;
		lseh_pos_t shift;
	} lseh_cmd_s;

	typedef struct packed {
		logic [1:0] enc_type;
		logic variant_b;
		logic no_ref_mark;
		logic soft_limit_en;
		logic cond_select;
		lseh_pos_t rev_counts;
	} lseh_cfg_s;

	typedef struct packed {
		lseh_state_e st;
		logic busy;
		logic done;
		logic err;
		logic [2:0] err_code;
		logic home_valid;
		lseh_pos_t home_pos;
		logic move_req;
		logic move_dir;
		logic ref_seen;
		logic base_valid;
		logic index_out;
		logic ref_d;
		logic reversed;
		logic [`LSEH_METH_W-1:0] method;
	} lseh_top_s;

endpackage

// >>> rtl/lseh_grid.sv
// reference home grid: one point per motor revolution from a base
// assumes position steps per cycle are smaller than one revolution
`timescale 1ns/10ps
module lseh_grid
	import lseh_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input lseh_pos_t pos,
	input wire logic load,
	input lseh_pos_t base,
	input lseh_pos_t rev_counts,
	output logic ready,
	output logic hit,
	output lseh_pos_t hit_pos
);
	typedef struct packed {
		lseh_pos_t phase;
		lseh_pos_t last_pos;
		logic ready;
		logic hit;
		lseh_pos_t hit_pos;
	} lseh_grid_s;

	lseh_grid_s q;
	lseh_grid_s n;
	lseh_pos_t p;

	always_comb begin
		n = q;
		n.hit = 1'b0;
		n.last_pos = pos;
		p = q.phase + (pos - q.last_pos);
		if (load) begin
			n.phase = pos - base;
			n.ready = 1'b0;
		end else if (p >= rev_counts) begin
			n.phase = p - rev_counts;
			n.hit = q.ready;
			n.hit_pos = pos - (p - rev_counts);
		end else if (p < 0) begin
			n.phase = p + rev_counts;
			n.hit = q.ready;
			n.hit_pos = pos - p;
		end else begin
			n.phase = p;
			n.ready = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign ready = q.ready;
	assign hit = q.hit;
	assign hit_pos = q.hit_pos;
endmodule

// >>> rtl/lseh_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous levels
`timescale 1ns/10ps
module lseh_sync #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} lseh_sync_s;

	lseh_sync_s q;
	lseh_sync_s n;

	always_comb begin
		n.s1 = din;
		n.s2 = q.s1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign dout = q.s2;
endmodule

// >>> rtl/lseh_top.sv
// load-side encoder homing controller for fully closed loop operation
// assumes load_pos and cmd come from logic on clk, the other pins are asynchronous
//
// What this block does
// - home taken from load-side position only
// - motor encoder index plays no part
// - absolute grid: every revolution from zero
// - dog method: next grid point after release
// - variant a: grid from first mark ever
// - variant b: grid from mark after start
// - home equals reference plus shift distance, except data set (current position, no shift)
// - method 33 runs opposite to 34
// - method -43 runs opposite to -11
// - stroke reversal refused with software limit
// - missing reference ends in error, retry
// - no mark, incremental: every method but data set refused
// - serial rotary: home at load index
// - condition select lets data set through
// - variant b incremental: index output off
`timescale 1ns/10ps
module lseh_top
	import lseh_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input lseh_cmd_s cmd,
	input lseh_cfg_s cfg,
	input lseh_pos_t load_pos,
	input wire logic ref_mark_pin,
	input wire logic dog_pin,
	input wire logic stroke_fwd_pin,
	input wire logic stroke_rev_pin,
	output logic busy,
	output logic done,
	output logic err,
	output logic [2:0] err_code,
	output logic home_valid,
	output lseh_pos_t home_pos,
	output logic move_req,
	output logic move_dir,
	output logic encoder_index_pulse_output
);
`include "lseh_defines.svh"

	// ----------------------------------------------------------
	// method decoding
	// ----------------------------------------------------------
	function automatic logic meth_index(input logic [`LSEH_METH_W-1:0] m);
		meth_index = (m == `LSEH_METH_IDX_POS) || (m == `LSEH_METH_IDX_NEG);
	endfunction

	function automatic logic meth_rev(input logic [`LSEH_METH_W-1:0] m);
		meth_rev = (m == `LSEH_METH_REV_POS) || (m == `LSEH_METH_REV_NEG);
	endfunction

	function automatic logic meth_fwd(input logic [`LSEH_METH_W-1:0] m);
		meth_fwd = (m == `LSEH_METH_IDX_POS) || (m == `LSEH_METH_REV_POS) ||
			(m == `LSEH_METH_DOG);
	endfunction

	function automatic lseh_top_s finish(input lseh_top_s s, input lseh_pos_t p);
		finish = s;
		finish.home_pos = p;
		finish.home_valid = 1'b1;
		finish.done = 1'b1;
		finish.busy = 1'b0;
		finish.move_req = 1'b0;
		finish.st = LSEH_IDLE;
	endfunction

	function automatic lseh_top_s fail(input lseh_top_s s, input logic [2:0] c);
		fail = s;
		fail.err = 1'b1;
		fail.err_code = c;
		fail.busy = 1'b0;
		fail.move_req = 1'b0;
		fail.st = LSEH_IDLE;
	endfunction

	// ----------------------------------------------------------
	// pin synchronisers and grid
	// ----------------------------------------------------------
	logic [3:0] sy;
	logic g_ready;
	logic g_hit;
	lseh_pos_t g_pos;
	logic grid_load;
	lseh_pos_t grid_base;

	lseh_sync #(.W(4)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.din({stroke_rev_pin, stroke_fwd_pin, dog_pin, ref_mark_pin}),
		.dout(sy)
	);

	lseh_grid u_grid (
		.clk(clk),
		.arst_n(arst_n),
		.pos(load_pos),
		.load(grid_load),
		.base(grid_base),
		.rev_counts(cfg.rev_counts),
		.ready(g_ready),
		.hit(g_hit),
		.hit_pos(g_pos)
	);

	// ----------------------------------------------------------
	// homing sequencer
	// ----------------------------------------------------------
	lseh_top_s q;
	lseh_top_s n;
	logic ref_edge;
	logic dog_on;
	logic stroke;
	logic is_abs;
	logic is_inc;
	logic is_rot;
	logic grid_ok;

	always_comb begin
		n = q;
		is_abs = (cfg.enc_type == `LSEH_ENC_ABS_LIN);
		is_inc = (cfg.enc_type == `LSEH_ENC_INC_LIN);
		is_rot = (cfg.enc_type == `LSEH_ENC_SER_ROT);
		ref_edge = sy[0] & ~q.ref_d;
		dog_on = sy[1];
		stroke = q.move_dir ? sy[2] : sy[3];
		grid_ok = g_ready & g_hit & q.base_valid;
		grid_load = 1'b0;
		grid_base = '0;
		n.ref_d = sy[0];
		n.index_out = ref_edge & ~(cfg.variant_b & is_inc);
		if (ref_edge) begin
			n.ref_seen = 1'b1;
		end
		if (is_inc && !cfg.variant_b && ref_edge && !q.ref_seen) begin
			grid_load = 1'b1;
			grid_base = load_pos;
			n.base_valid = 1'b1;
		end
		if (is_inc && cfg.variant_b && ref_edge && q.busy && !q.base_valid) begin
			grid_load = 1'b1;
			grid_base = load_pos;
			n.base_valid = 1'b1;
		end
		case (q.st)
			LSEH_IDLE: begin
				if (cmd.start) begin
					n.done = 1'b0;
					n.err = 1'b0;
					n.err_code = `LSEH_ERR_NONE;
					n.method = cmd.method;
					n.reversed = 1'b0;
					if (is_abs) begin
						grid_load = 1'b1;
						grid_base = '0;
						n.base_valid = 1'b1;
					end
					if (is_inc && cfg.variant_b) begin
						n.base_valid = 1'b0;
					end
					if (cmd.method == `LSEH_METH_DATASET) begin
						if (q.ref_seen || cfg.cond_select) begin
							n = finish(n, load_pos);
						end else begin
							n = fail(n, `LSEH_ERR_NOREF);
						end
					end else if (meth_rev(cmd.method) && cfg.soft_limit_en) begin
						n = fail(n, `LSEH_ERR_SOFTLIM);
					end else if (is_inc && cfg.no_ref_mark) begin
						n = fail(n, `LSEH_ERR_NOIDX);
					end else if (!meth_index(cmd.method) && !meth_rev(cmd.method) &&
						cmd.method != `LSEH_METH_DOG) begin
						n = fail(n, `LSEH_ERR_BADMETH);
					end else begin
						n.busy = 1'b1;
						n.move_req = 1'b1;
						n.move_dir = meth_fwd(cmd.method);
						n.st = LSEH_SEEK;
					end
				end
			end
			LSEH_SEEK: begin
				if (meth_index(q.method)) begin
					if (!is_abs && ref_edge) begin
						n = finish(n, load_pos + cmd.shift);
					end else if (is_abs && grid_ok) begin
						n = finish(n, g_pos + cmd.shift);
					end else if (stroke) begin
						n = fail(n, `LSEH_ERR_NOREF);
					end
				end else if (dog_on) begin
					n.st = LSEH_DOG;
				end else if (stroke) begin
					if (meth_rev(q.method) && !q.reversed) begin
						n.move_dir = ~q.move_dir;
						n.reversed = 1'b1;
					end else begin
						n = fail(n, `LSEH_ERR_NOREF);
					end
				end
			end
			LSEH_DOG: begin
				if (!dog_on) begin
					if (is_inc && !n.base_valid) begin
						n = fail(n, `LSEH_ERR_NOREF);
					end else begin
						n.st = LSEH_GRID;
					end
				end else if (stroke) begin
					n = fail(n, `LSEH_ERR_NOREF);
				end
			end
			LSEH_GRID: begin
				if (is_rot && ref_edge) begin
					n = finish(n, load_pos + cmd.shift);
				end else if (!is_rot && grid_ok) begin
					n = finish(n, g_pos + cmd.shift);
				end else if (stroke) begin
					n = fail(n, `LSEH_ERR_NOREF);
				end
			end
			default: begin
				n.st = LSEH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.st <= LSEH_IDLE;
			q.move_dir <= `LSEH_RST_DIR;
			q.err_code <= `LSEH_ERR_NONE;
		end else begin
			q <= n;
		end
	end

	assign busy = q.busy;
	assign done = q.done;
	assign err = q.err;
	assign err_code = q.err_code;
	assign home_valid = q.home_valid;
	assign home_pos = q.home_pos;
	assign move_req = q.move_req;
	assign move_dir = q.move_dir;
	assign encoder_index_pulse_output = q.index_out;

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_idle_start(logic [`LSEH_METH_W-1:0] m);
		q.st == LSEH_IDLE && cmd.start && cmd.method == m;
	endsequence

	sequence s_dog_release;
		q.st == LSEH_DOG && !dog_on && !(is_inc && !n.base_valid);
	endsequence

	a_dataset_gate: assert property (s_idle_start(`LSEH_METH_DATASET) and
		(!q.ref_seen && !cfg.cond_select) |=> err && err_code == `LSEH_ERR_NOREF && !done)
		else $error("data set accepted without reference");
	a_dataset_cond: assert property (s_idle_start(`LSEH_METH_DATASET) and cfg.cond_select
		|=> done && home_valid && home_pos == $past(load_pos))
		else $error("data set not taken with condition select");
	a_softlim_block: assert property (q.st == LSEH_IDLE && cmd.start && meth_rev(cmd.method) &&
		cfg.soft_limit_en |=> err && err_code == `LSEH_ERR_SOFTLIM && !move_req)
		else $error("reversal method ran with software limit");
	a_noidx_block: assert property (q.st == LSEH_IDLE && cmd.start && is_inc && cfg.no_ref_mark &&
		cmd.method != `LSEH_METH_DATASET && !cfg.soft_limit_en |=> err_code == `LSEH_ERR_NOIDX)
		else $error("index method ran without reference mark");
	a_dir_pair: assert property (s_idle_start(`LSEH_METH_IDX_NEG) and
		!(is_inc && cfg.no_ref_mark) |=> move_req && !move_dir ##1 !move_dir || !move_req)
		else $error("method 33 direction wrong");
	a_rev_pair: assert property (s_idle_start(`LSEH_METH_REV_NEG) and
		!cfg.soft_limit_en && !(is_inc && cfg.no_ref_mark) |=> move_req && !move_dir)
		else $error("method -43 direction wrong");
	a_index_mute: assert property (cfg.variant_b && is_inc && $stable(cfg) |=>
		!encoder_index_pulse_output)
		else $error("index output active on variant b");
	a_noref_err: assert property (q.st == LSEH_SEEK && meth_index(q.method) && stroke &&
		!ref_edge && !grid_ok |=> err && !busy ##1 !move_req)
		else $error("stroke end without reference not flagged");
	a_grid_home: assert property (s_dog_release ##[1:300] (q.st == LSEH_GRID && !is_rot && grid_ok)
		|=> done && home_pos == $past(g_pos) + $past(cmd.shift))
		else $error("dog home not at grid point plus shift");
	a_shift_home: assert property (q.st == LSEH_SEEK && meth_index(q.method) && is_inc &&
		ref_edge |=> home_valid && home_pos == $past(load_pos) + $past(cmd.shift))
		else $error("home not at reference plus shift");
	a_varb_base: assert property (q.st == LSEH_IDLE && cmd.start && is_inc && cfg.variant_b
		&& !ref_edge |=> !q.base_valid)
		else $error("variant b grid base kept from before start");
endmodule
